// ==== src/fps_params.svh ====
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

// Timebase
`define FPS_CLK_MHZ 200

// Delays in their own units
`define FPS_FAULT_MS 128
`define FPS_HI_BLANK_US 50
`define FPS_LO_BLANK_US 350
`define FPS_AUTOREC_US 1000
`define FPS_SOFTSTART_US 1000

// Derived cycle counts
`define FPS_FAULT_CYC (`FPS_FAULT_MS * 1000 * `FPS_CLK_MHZ)
`define FPS_HI_BLANK_CYC (`FPS_HI_BLANK_US * `FPS_CLK_MHZ)
`define FPS_LO_BLANK_CYC (`FPS_LO_BLANK_US * `FPS_CLK_MHZ)
`define FPS_AUTOREC_CYC (`FPS_AUTOREC_US * `FPS_CLK_MHZ)
`define FPS_SOFTSTART_CYC (`FPS_SOFTSTART_US * `FPS_CLK_MHZ)

// Feedback level codes
`define FPS_FB_FOLD_START 8'h60
`define FPS_FB_FOLD_END 8'h30
`define FPS_FB_SKIP_OUT 8'h28
`define FPS_FB_SKIP_IN 8'h20

// Oscillator frequency codes
`define FPS_FREQ_MIN 8'h1F
`define FPS_FREQ_NOM 8'h7F
`define FPS_FREQ_SHIFT 1

// Timer counter width
`define FPS_CNT_W 32
`define FPS_CNT_ZERO 32'h0000_0000
`define FPS_CNT_ONE 32'h0000_0001

`endif

// ==== src/fps_pkg.sv ====
package fps_pkg;

  typedef enum logic [2:0] {
    FPS_OFF = 3'b000,
    FPS_CHECK = 3'b001,
    FPS_SOFT = 3'b010,
    FPS_RUN = 3'b011,
    FPS_AUTOREC = 3'b100,
    FPS_LATCHED = 3'b101
  } fps_state_t;

endpackage : fps_pkg

// ==== src/fps_hold_timer.sv ====
`timescale 1ns/1ps
`include "fps_params.svh"

// Trips once level has stood enabled for LIMIT consecutive cycles
module fps_hold_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Condition
  input wire logic enable,
  input wire logic level,
  // Result
  output logic trip
);

  localparam logic [`FPS_CNT_W-1:0] LIMIT_W = LIMIT[`FPS_CNT_W-1:0];

  logic [`FPS_CNT_W-1:0] cnt_q;
  logic [`FPS_CNT_W-1:0] cnt_d;
  wire counting = enable & level;

  // Saturate so a long excursion stays tripped
  assign cnt_d = !counting ? `FPS_CNT_ZERO : (trip ? cnt_q : cnt_q + `FPS_CNT_ONE);
  assign trip = (cnt_q >= LIMIT_W);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= `FPS_CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule : fps_hold_timer

// ==== src/fps_sequencer.sv ====
`timescale 1ns/1ps
`include "fps_params.svh"

// Contract
// - Current limit starts the overload fault timer
// - Expiry stops drive, latches or autorecovers
// - Setpoint back below limit clears timer
// - Max duty termination also starts timer
// - Autorecovery restarts after delay, retries on fault
// - Low feedback folds frequency linearly to minimum
// - Current-mode termination stays active during foldback
// - No foldback while at maximum duty
// - Skip-entry threshold stops drive, lowers consumption
// - Stay skipping until skip-exit threshold crossed
// - Shutdown input outside window latches off
// - Blank 50 us high, 350 us low excursions
// - Latch cleared only by brown-out, supply reset or over-temperature
// - Upper threshold checked at supply start level
// - Lower threshold ignored until soft-start ends
// - Double thermistor bias during soft-start
// - Over-temperature stops drive, source, resets logic
// - Cooling re-enables source, normal start-up
// - Brown-out stops; resume above start level
module fps_sequencer #(
  parameter int unsigned FAULT_CYC = `FPS_FAULT_CYC,
  parameter int unsigned HI_BLANK_CYC = `FPS_HI_BLANK_CYC,
  parameter int unsigned LO_BLANK_CYC = `FPS_LO_BLANK_CYC,
  parameter int unsigned AUTOREC_CYC = `FPS_AUTOREC_CYC,
  parameter int unsigned SOFTSTART_CYC = `FPS_SOFTSTART_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Option strap
  input wire logic option_autorec,
  // Supply and line sense
  input wire logic supply_at_start,
  input wire logic supply_at_reset,
  input wire logic line_above_start,
  input wire logic line_below_stop,
  // Current loop
  input wire logic cs_at_limit,
  input wire logic max_duty_term,
  input wire logic cs_term,
  input wire logic [7:0] feedback_level,
  // Shutdown window
  input wire logic shutdown_above_upper,
  input wire logic shutdown_below_lower,
  // Temperature
  input wire logic over_temperature_shutdown,
  // Gate drive and supply control
  output logic gate_drive_out,
  output logic startup_source_en,
  output logic soft_start_bias_current,
  output logic cm_term_enable,
  // Oscillator
  output logic [7:0] osc_freq_code,
  // Status
  output logic skip_active,
  output logic low_power,
  output logic latched_off,
  output logic fault_timer_running
);

  fps_pkg::fps_state_t state_q;
  fps_pkg::fps_state_t state_d;
  logic opt_autorec_q;
  logic skip_q;
  logic skip_d;
  logic max_duty_q;
  logic max_duty_d;
  logic gate_q;
  logic startup_q;
  logic bias_q;
  logic [7:0] freq_q;
  logic [7:0] freq_d;

  function automatic logic [7:0] fps_clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    fps_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : fps_clamp

  // Decoding
  wire st_soft = (state_q == fps_pkg::FPS_SOFT);
  wire st_run = (state_q == fps_pkg::FPS_RUN);
  wire st_active = st_soft | st_run;
  wire st_latched = (state_q == fps_pkg::FPS_LATCHED);
  wire hot = over_temperature_shutdown;
  wire brownout = line_below_stop;
  wire fb_at_skip_in = (feedback_level <= `FPS_FB_SKIP_IN);
  wire fb_above_skip_out = (feedback_level > `FPS_FB_SKIP_OUT);
  wire [7:0] fb_clamped = fps_clamp(feedback_level, `FPS_FB_FOLD_END, `FPS_FB_FOLD_START);
  wire [7:0] fb_span = fb_clamped - `FPS_FB_FOLD_END;
  wire [7:0] freq_fold = `FPS_FREQ_MIN + (fb_span << `FPS_FREQ_SHIFT);
  wire fault_level = (cs_at_limit | max_duty_q) & st_active;
  wire fault_trip;
  wire hi_trip;
  wire lo_trip;
  wire autorec_done;
  wire soft_done;

  // Fault timer: cleared the moment the level drops
  fps_hold_timer #(.LIMIT(FAULT_CYC)) u_fault (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(~hot),
    .level(fault_level),
    .trip(fault_trip)
  );

  // Upper window edge watched from the start-level check onward
  fps_hold_timer #(.LIMIT(HI_BLANK_CYC)) u_hi_blank (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(~hot & (st_active | (state_q == fps_pkg::FPS_CHECK))),
    .level(shutdown_above_upper),
    .trip(hi_trip)
  );

  // Lower edge masked through soft-start; references may still settle
  fps_hold_timer #(.LIMIT(LO_BLANK_CYC)) u_lo_blank (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(~hot & st_run),
    .level(shutdown_below_lower),
    .trip(lo_trip)
  );

  fps_hold_timer #(.LIMIT(AUTOREC_CYC)) u_autorec (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(~hot),
    .level(state_q == fps_pkg::FPS_AUTOREC),
    .trip(autorec_done)
  );

  fps_hold_timer #(.LIMIT(SOFTSTART_CYC)) u_soft (
    .mclk(mclk),
    .reset_n(reset_n),
    .enable(~hot),
    .level(st_soft),
    .trip(soft_done)
  );

  // Sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      fps_pkg::FPS_OFF: begin
        if (supply_at_start && line_above_start) begin
          state_d = fps_pkg::FPS_CHECK;
        end
      end
      fps_pkg::FPS_CHECK: begin
        state_d = shutdown_above_upper ? fps_pkg::FPS_LATCHED : fps_pkg::FPS_SOFT;
      end
      fps_pkg::FPS_SOFT, fps_pkg::FPS_RUN: begin
        if (hi_trip || lo_trip) begin
          state_d = fps_pkg::FPS_LATCHED;
        end else if (fault_trip) begin
          state_d = opt_autorec_q ? fps_pkg::FPS_AUTOREC : fps_pkg::FPS_LATCHED;
        end else if (st_soft && soft_done) begin
          state_d = fps_pkg::FPS_RUN;
        end
      end
      fps_pkg::FPS_AUTOREC: begin
        if (autorec_done) begin
          state_d = fps_pkg::FPS_CHECK;
        end
      end
      fps_pkg::FPS_LATCHED: begin
        state_d = fps_pkg::FPS_LATCHED;
      end
      default: begin
        state_d = fps_pkg::FPS_OFF;
      end
    endcase
    // Brown-out and supply reset clear everything, latch included
    if (brownout || supply_at_reset) begin
      state_d = fps_pkg::FPS_OFF;
    end
    if (hot) begin
      state_d = fps_pkg::FPS_OFF;
    end
  end

  // Skip hysteresis, only meaningful while running
  assign skip_d = st_run & ~hot & (skip_q ? ~fb_above_skip_out : fb_at_skip_in);

  // Max duty flag persists until a current-terminated pulse; a new max duty pulse wins
  assign max_duty_d = st_active & ~hot & (max_duty_term | (max_duty_q & ~cs_term));

  // Foldback held at nominal when at maximum duty
  assign freq_d = (max_duty_q || !st_active) ? `FPS_FREQ_NOM : freq_fold;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      opt_autorec_q <= option_autorec;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_q <= fps_pkg::FPS_OFF;
      skip_q <= 1'b0;
      max_duty_q <= 1'b0;
      freq_q <= `FPS_FREQ_NOM;
    end else begin
      state_q <= state_d;
      skip_q <= skip_d;
      max_duty_q <= max_duty_d;
      freq_q <= freq_d;
    end
  end

  // Output flops
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      gate_q <= 1'b0;
      startup_q <= 1'b0;
      bias_q <= 1'b0;
    end else begin
      gate_q <= ~hot & ((state_d == fps_pkg::FPS_SOFT) | (state_d == fps_pkg::FPS_RUN)) & ~skip_d;
      startup_q <= ~hot;
      bias_q <= ~hot & (state_d == fps_pkg::FPS_SOFT);
    end
  end

  assign gate_drive_out = gate_q;
  assign startup_source_en = startup_q;
  assign soft_start_bias_current = bias_q;
  assign cm_term_enable = st_active;
  assign osc_freq_code = freq_q;
  assign skip_active = skip_q;
  assign low_power = skip_q;
  assign latched_off = st_latched;
  assign fault_timer_running = fault_level & ~hot;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_ot_quiet;
    !gate_drive_out && !startup_source_en && state_q == fps_pkg::FPS_OFF;
  endsequence

  sequence s_drive_stopped;
    !gate_drive_out ##1 !gate_drive_out;
  endsequence

  property p_ot_stop;
    over_temperature_shutdown |=> s_ot_quiet;
  endproperty
  a_ot_stop: assert property (p_ot_stop) else $error("over-temperature did not stop");

  property p_ot_release;
    $fell(over_temperature_shutdown) |-> startup_source_en == 1'b0 ##1 startup_source_en;
  endproperty
  a_ot_release: assert property (p_ot_release) else $error("start-up source not restored");

  property p_fault_expire;
    st_active && fault_trip && !hi_trip && !lo_trip && !brownout && !supply_at_reset && !hot
      |=> (state_q == (opt_autorec_q ? fps_pkg::FPS_AUTOREC : fps_pkg::FPS_LATCHED)) ##0 s_drive_stopped;
  endproperty
  a_fault_expire: assert property (p_fault_expire) else $error("fault expiry mishandled");

  property p_fault_clear;
    !fault_level |=> !fault_trip;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault timer not cleared");

  property p_skip_enter;
    st_run && state_d == fps_pkg::FPS_RUN && !skip_q && fb_at_skip_in && !hot |=> skip_q ##0 !gate_drive_out;
  endproperty
  a_skip_enter: assert property (p_skip_enter) else $error("skip not entered");

  property p_skip_exit;
    skip_q && st_run && state_d == fps_pkg::FPS_RUN && fb_above_skip_out && !hot |=> !skip_q ##0 gate_drive_out;
  endproperty
  a_skip_exit: assert property (p_skip_exit) else $error("skip not left");

  property p_latch_hold;
    st_latched && !brownout && !supply_at_reset && !hot |=> st_latched;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch released early");

  property p_check;
    state_q == fps_pkg::FPS_CHECK && shutdown_above_upper && !brownout && !supply_at_reset && !hot
      |=> st_latched && !gate_drive_out;
  endproperty
  a_check: assert property (p_check) else $error("start permitted over upper threshold");

  property p_lo_mask;
    st_soft |-> !lo_trip;
  endproperty
  a_lo_mask: assert property (p_lo_mask) else $error("lower threshold seen in soft-start");

  property p_bias;
    ##1 soft_start_bias_current == (state_q == fps_pkg::FPS_SOFT);
  endproperty
  a_bias: assert property (p_bias) else $error("bias current not tracking soft-start");

  property p_fold_max_duty;
    max_duty_q |=> osc_freq_code == `FPS_FREQ_NOM;
  endproperty
  a_fold_max_duty: assert property (p_fold_max_duty) else $error("foldback while at max duty");

  property p_fold_min;
    st_active && !max_duty_q && feedback_level <= `FPS_FB_FOLD_END |=> osc_freq_code == `FPS_FREQ_MIN;
  endproperty
  a_fold_min: assert property (p_fold_min) else $error("minimum frequency not reached");

  property p_brownout;
    line_below_stop |=> state_q == fps_pkg::FPS_OFF ##0 !gate_drive_out;
  endproperty
  a_brownout: assert property (p_brownout) else $error("brown-out did not stop");

  property p_option;
    ##1 $stable(opt_autorec_q);
  endproperty
  a_option: assert property (p_option) else $error("option changed after reset");

endmodule : fps_sequencer

// ==== verif/fps_drive_model.sv ====
`timescale 1ns/1ps

// Gate driver and pulse-end comparators: one termination per four-cycle pulse
module fps_drive_model (
  // Clock
  input wire logic mclk,
  // Drive and mode
  input wire logic gate_drive_out,
  input wire logic max_duty_mode,
  // Terminations
  output logic cs_term,
  output logic max_duty_term
);
  logic [1:0] phase_q = 2'h0;
  logic cs_q = 1'b0;
  logic md_q = 1'b0;
  // No pulse ends while the gate is idle
  always @(posedge mclk) begin
    phase_q <= gate_drive_out ? phase_q + 2'h1 : 2'h0;
    cs_q <= gate_drive_out && phase_q == 2'h3 && !max_duty_mode;
    md_q <= gate_drive_out && phase_q == 2'h3 && max_duty_mode;
  end
  assign cs_term = cs_q;
  assign max_duty_term = md_q;
endmodule : fps_drive_model

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`include "fps_params.svh"

module tb;
  localparam int unsigned fc = 20, hc = 5, lc = 9, ac = 15, sc = 12;
  logic mclk = 1'b0, reset_n = 1'b0, opt = 1'b0, sup_on = 1'b0, sup_rst = 1'b0;
  logic l_on = 1'b0, l_off = 1'b0, cs_lim = 1'b0, up = 1'b0, lo = 1'b0, hot = 1'b0, mode = 1'b0;
  logic [7:0] fb = 8'h80;
  logic cs_term, md_term, gate, src, bias, cm_en, skip, lowp, latch, ftr;
  logic [7:0] osc;
  logic [5:0] obs;
  int failures = 0, comparisons = 0;
  assign obs = {src, ftr, bias, skip, latch, gate};

  always #2.5 mclk = ~mclk;

  fps_sequencer #(.FAULT_CYC(fc), .HI_BLANK_CYC(hc), .LO_BLANK_CYC(lc), .AUTOREC_CYC(ac),
    .SOFTSTART_CYC(sc)) fps_sequencer_i (.mclk(mclk), .reset_n(reset_n), .option_autorec(opt),
    .supply_at_start(sup_on), .supply_at_reset(sup_rst), .line_above_start(l_on),
    .line_below_stop(l_off), .cs_at_limit(cs_lim), .max_duty_term(md_term), .cs_term(cs_term),
    .feedback_level(fb), .shutdown_above_upper(up), .shutdown_below_lower(lo),
    .over_temperature_shutdown(hot), .gate_drive_out(gate), .startup_source_en(src),
    .soft_start_bias_current(bias), .cm_term_enable(cm_en), .osc_freq_code(osc),
    .skip_active(skip), .low_power(lowp), .latched_off(latch), .fault_timer_running(ftr));

  fps_drive_model fps_drive_model_i (.mclk(mclk), .gate_drive_out(gate), .max_duty_mode(mode),
    .cs_term(cs_term), .max_duty_term(md_term));

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Polls at the falling edge so registered outputs have settled
  task automatic wait_obs(input int b, input logic v, input int lim, input string nm);
    int i;
    for (i = 0; i < lim; i++) begin
      @(negedge mclk);
      if (obs[b] === v) break;
    end
    chk(nm, obs[b], v);
  endtask : wait_obs

  task automatic power_up(input logic o, input logic u, input logic l);
    @(posedge mclk);
    reset_n <= 1'b0; opt <= o; sup_on <= 1'b1; l_on <= 1'b1; l_off <= 1'b0; sup_rst <= 1'b0;
    cs_lim <= 1'b0; up <= u; lo <= l; hot <= 1'b0; fb <= 8'h80; mode <= 1'b0;
    tick(10);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk("osc_reset", osc, `FPS_FREQ_NOM);
  endtask : power_up

  task automatic run_up();
    wait_obs(0, 1'b1, 10, "gate_on");
    chk("bias_soft", bias, 1'b1);
    chk("cm_soft", cm_en, 1'b1);
    wait_obs(3, 1'b0, sc + 10, "bias_end");
  endtask : run_up

  task automatic s_window();
    power_up(0, 1'b1, 1'b0);
    wait_obs(1, 1'b1, 5, "upper_start");
    chk("gate_upper", gate, 1'b0);
    power_up(0, 1'b0, 1'b1);
    run_up();
    chk("lower_soft", latch, 1'b0);
    wait_obs(1, 1'b1, lc + 5, "lower_run");
    chk("gate_lower", gate, 1'b0);
  endtask : s_window

  task automatic s_blank();
    power_up(0, 1'b0, 1'b0);
    run_up();
    @(posedge mclk) up <= 1'b1;
    tick(hc - 1);
    up <= 1'b0; lo <= 1'b1;
    tick(lc - 1);
    lo <= 1'b0;
    tick(3);
    @(negedge mclk) chk("short_spikes", latch, 1'b0);
    @(posedge mclk) up <= 1'b1;
    wait_obs(1, 1'b1, hc + 4, "long_upper");
    @(posedge mclk) begin
      up <= 1'b0; l_off <= 1'b1; l_on <= 1'b0;
    end
    wait_obs(1, 1'b0, 3, "brownout_clear");
    chk("brownout_gate", gate, 1'b0);
    @(posedge mclk) begin
      l_off <= 1'b0; l_on <= 1'b1;
    end
    wait_obs(0, 1'b1, 10, "line_back");
  endtask : s_blank

  task automatic s_fault();
    power_up(0, 1'b0, 1'b0);
    run_up();
    @(posedge mclk) cs_lim <= 1'b1;
    @(negedge mclk) chk("timer_start", ftr, 1'b1);
    tick(fc - 6);
    cs_lim <= 1'b0;
    @(negedge mclk) chk("timer_clear", ftr, 1'b0);
    @(posedge mclk) cs_lim <= 1'b1;
    tick(fc - 2);
    @(negedge mclk) chk("timer_restart", latch, 1'b0);
    wait_obs(1, 1'b1, 8, "fault_latch");
    chk("fault_gate", gate, 1'b0);
    @(posedge mclk) begin
      sup_rst <= 1'b1; cs_lim <= 1'b0;
    end
    wait_obs(1, 1'b0, 3, "supply_reset");
  endtask : s_fault

  task automatic s_autorec();
    power_up(1, 1'b0, 1'b0);
    run_up();
    @(posedge mclk) cs_lim <= 1'b1;
    wait_obs(0, 1'b0, fc + 5, "ar_stop");
    chk("ar_no_latch", latch, 1'b0);
    wait_obs(0, 1'b1, ac + 5, "ar_retry");
    wait_obs(0, 1'b0, sc + fc + 8, "ar_burst");
    @(posedge mclk) cs_lim <= 1'b0;
    wait_obs(0, 1'b1, ac + 5, "ar_restart");
    run_up();
    tick(fc + 5);
    @(negedge mclk) chk("ar_resume", gate, 1'b1);
  endtask : s_autorec

  task automatic s_light();
    logic [7:0] tbl [3] = '{8'h70, 8'h48, 8'h30};
    logic [7:0] e;
    power_up(0, 1'b0, 1'b0);
    run_up();
    foreach (tbl[i]) begin
      e = tbl[i] >= `FPS_FB_FOLD_START ? `FPS_FREQ_NOM : `FPS_FREQ_MIN + 8'(2 * (tbl[i] - 8'h30));
      @(posedge mclk) fb <= tbl[i];
      tick(3);
      @(negedge mclk) chk("fold_code", osc, e);
      chk("fold_cm", cm_en, 1'b1);
    end
    @(posedge mclk) begin
      fb <= 8'h40; mode <= 1'b1;
    end
    wait_obs(4, 1'b1, 10, "maxduty_timer");
    @(negedge mclk) chk("maxduty_nofold", osc, `FPS_FREQ_NOM);
    @(posedge mclk) mode <= 1'b0;
    wait_obs(4, 1'b0, 10, "maxduty_clear");
    @(posedge mclk) fb <= `FPS_FB_SKIP_IN;
    wait_obs(2, 1'b1, 3, "skip_in");
    chk("skip_gate", gate, 1'b0);
    chk("skip_power", lowp, 1'b1);
    @(posedge mclk) fb <= 8'h24;
    tick(5);
    @(negedge mclk) chk("skip_hold", skip, 1'b1);
    @(posedge mclk) fb <= 8'h29;
    wait_obs(0, 1'b1, 4, "skip_out");
    @(posedge mclk) begin
      l_off <= 1'b1; l_on <= 1'b0;
    end
    wait_obs(0, 1'b0, 3, "brownout_run");
    tick(5);
    @(negedge mclk) chk("line_low_hold", gate, 1'b0);
  endtask : s_light

  task automatic s_hot();
    power_up(0, 1'b0, 1'b0);
    run_up();
    @(posedge mclk) hot <= 1'b1;
    wait_obs(0, 1'b0, 2, "hot_gate");
    wait_obs(5, 1'b0, 3, "hot_source");
    @(posedge mclk) hot <= 1'b0;
    wait_obs(5, 1'b1, 3, "cool_source");
    wait_obs(0, 1'b1, 10, "cool_start");
  endtask : s_hot

  task automatic report_and_stop();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // Run needs well under 2000 cycles
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end

  initial begin
    s_window();
    s_blank();
    s_fault();
    s_autorec();
    s_light();
    s_hot();
    report_and_stop();
  end
endmodule : tb
